/* logic/gpio_pkg.sv */
// Constants shared by the two-port GPIO block.
// Assumes a plain register port with one-cycle strobes and registered read data.
package gpio_pkg;
  localparam int          ADDR_W          = 3;
  localparam int          PORT_W          = 8;
  // Register indices on the plain register port
  localparam logic [2:0]  ADDR_P1_DIR     = 3'h0;
  localparam logic [2:0]  ADDR_P1_DATA    = 3'h1;
  localparam logic [2:0]  ADDR_P1_PULLUP  = 3'h2;
  localparam logic [2:0]  ADDR_P2_DIR     = 3'h3;
  localparam logic [2:0]  ADDR_P2_DATA    = 3'h4;
  localparam logic [2:0]  ADDR_STATUS     = 3'h5;
  // Reset values
  localparam logic [7:0]  P1_RESET        = 8'h00;
  localparam logic [7:0]  P2_DIR_MODE1    = 8'h40;
  localparam logic [7:0]  P2_DIR_MODE23   = 8'h00;
  localparam logic [7:0]  P2_DATA_RESET   = 8'h00;
  // Second-port pin positions
  localparam int          PIN_WAIT        = 7;
  localparam int          PIN_CLK         = 6;
  localparam int          PIN_AS          = 5;
  localparam int          PIN_WR          = 4;
  localparam int          PIN_RD          = 3;
  // Mask of pins 5..3 that the bus strobes take over
  localparam logic [7:0]  STROBE_MASK     = 8'h38;
  // Wait mode selection for pin 7 while expanded
  typedef enum logic [1:0] {WAIT_GPIO, WAIT_BUS, WAIT_I2C} wait_sel_e;
  localparam logic [1:0]  MODE_ONE        = 2'h1;
endpackage

/* logic/gpio_ports.sv */
// Two 8-bit GPIO ports: first port with pull-ups and data-bus role,
// second port with bus strobes, wait, clock out and subclock in.
// Assumes a plain register port and asynchronous pins.
// How it works
// - First-port pull-up bits are per pin, software controlled, reset to zero.
// - Unexpanded modes 2/3 pull up a pin only if bit set and input.
// - Pull-ups off in reset, hardware standby, mode 1 or expansion enabled.
// - Software standby and run: pull-up equals not-direction and pull-up bit.
// - Expanded, first port is the data bus and direction bits are ignored.
// - Unexpanded, first-port direction bit one means output, zero input.
// - Second-port direction resets to 0x40 in mode 1, 0x00 otherwise.
// - Expanded, pin 7 is wait input, I2C data or GPIO by wait mode.
// - Expanded, pin 6 drives system clock when its direction bit is set.
// - Expanded, pins 5..3 are address, write and read strobes.
// - Expanded, pins 2..0 are GPIO following their direction bits.
// - Unexpanded, pin 6 set is clock out, other set pins outputs.
// - Second-port read gives data bit for outputs, pin level for inputs.
// - Second-port data register holds general output data except bit 6.
// - Bit 6 of second-port data follows pin 6 after reset; others clear.
// - First-port read gives data bit for outputs, pin level for inputs.
`timescale 1ns/1ps
module gpio_ports
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Operating state
  input  wire logic [1:0]        op_mode,
  input  wire logic              external_expansion_enable,
  input  wire logic              hw_standby,
  input  wire logic [1:0]        wait_sel,
  input  wire logic              i2c_drive_low,
  input  wire logic [2:0]        strobes_n,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // First port pins and data bus
  input  wire logic [7:0]        first_pin_in,
  output logic      [7:0]        first_pin_out,
  output logic      [7:0]        first_pin_oe_n,
  output logic      [7:0]        first_pin_pullup,
  input  wire logic              bus_data_drive,
  input  wire logic [7:0]        bus_wdata,
  output logic      [7:0]        bus_rdata,
  // Second port pins
  input  wire logic [7:0]        second_pin_in,
  output logic      [7:0]        second_pin_out,
  output logic      [7:0]        second_pin_oe_n,
  output logic                   bus_wait,
  output logic                   subclock_input
);
  logic [7:0] first_port_dir;
  logic [7:0] first_port_out_data;
  logic [7:0] first_port_pullup_ctrl;
  logic [7:0] second_port_dir;
  logic [7:0] second_port_out_data;
  logic [7:0] first_sync;
  logic [7:0] second_sync;
  logic [7:0] mux_drive;
  logic [7:0] mux_level;
  logic       expand;
  logic       clk_phase;
  logic       seeded;
  logic       mode1_seen;
  logic       p6_follow;
  logic [7:0] next_rdata;

  // Mode 1 always works expanded
  assign expand = (op_mode == MODE_ONE) || external_expansion_enable;

  pin_sync u_first_sync (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .pin_raw    (first_pin_in),
    .pin_sync_q (first_sync)
  );

  pin_sync u_second_sync (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .pin_raw    (second_pin_in),
    .pin_sync_q (second_sync)
  );

  port_pin_mux u_mux (
    .expand        (expand),
    .wait_sel      (wait_sel),
    .dir           (second_port_dir),
    .data          (second_port_out_data),
    .clk_phase     (clk_phase),
    .strobes_n     (strobes_n),
    .i2c_drive_low (i2c_drive_low),
    .drive         (mux_drive),
    .level         (mux_level)
  );

  // System clock image, toggling each cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) clk_phase <= 1'b0;
    else clk_phase <= ~clk_phase;
  end

  // First-port registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      first_port_dir         <= P1_RESET;
      first_port_out_data    <= P1_RESET;
      first_port_pullup_ctrl <= P1_RESET;
    end else if (wr) begin
      unique case (addr)
        ADDR_P1_DIR:    first_port_dir         <= wdata;
        ADDR_P1_DATA:   first_port_out_data    <= wdata;
        ADDR_P1_PULLUP: first_port_pullup_ctrl <= wdata;
        default: ;
      endcase
    end
  end

  // Mode strap caught once after reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seeded     <= 1'b0;
      mode1_seen <= 1'b0;
    end else if (!seeded) begin
      seeded     <= 1'b1;
      mode1_seen <= (op_mode == MODE_ONE);
    end
  end

  // Second-port direction; loaded from the mode on the first clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      second_port_dir <= P2_DIR_MODE23;
    end else if (!seeded) begin
      second_port_dir <= (op_mode == MODE_ONE) ? P2_DIR_MODE1 : P2_DIR_MODE23;
    end else if (wr && addr == ADDR_P2_DIR) begin
      second_port_dir <= wdata;
    end
  end

  // Second-port data; bit 6 takes the pin level until software owns it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      second_port_out_data <= P2_DATA_RESET;
    end else if (!seeded) begin
      second_port_out_data[PIN_CLK] <= second_sync[PIN_CLK];
    end else if (wr && addr == ADDR_P2_DATA) begin
      second_port_out_data <= wdata;
    end else if (p6_follow) begin
      second_port_out_data[PIN_CLK] <= second_sync[PIN_CLK];
    end
  end

  // Bit 6 keeps tracking the pin until written or until pin 6 turns output;
  // the synchroniser still holds its reset value at release, so one sample is not enough
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      p6_follow <= 1'b1;
    end else if (seeded && (second_port_dir[PIN_CLK] || (wr && addr == ADDR_P2_DATA))) begin
      p6_follow <= 1'b0;
    end
  end

  // Readback, one cycle after the strobe; direction reads are side-effect free
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      ADDR_P1_DIR:    next_rdata = first_port_dir;
      ADDR_P1_DATA:   next_rdata = (first_port_dir & first_port_out_data)
                                 | (~first_port_dir & first_sync);
      ADDR_P1_PULLUP: next_rdata = first_port_pullup_ctrl;
      ADDR_P2_DIR:    next_rdata = second_port_dir;
      ADDR_P2_DATA:   next_rdata = (second_port_dir & second_port_out_data)
                                 | (~second_port_dir & second_sync);
      ADDR_STATUS:    next_rdata = {6'h00, mode1_seen, expand};
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rdata <= 8'h00;
    else if (rd) rdata <= next_rdata;
    else rdata <= 8'h00;
  end

  // First-port pin drive and pull-ups
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      first_pin_out    <= 8'h00;
      first_pin_oe_n   <= 8'hff;
      first_pin_pullup <= 8'h00;
      bus_rdata        <= 8'h00;
    end else begin
      bus_rdata <= first_sync;
      if (expand) begin
        first_pin_out    <= bus_wdata;
        first_pin_oe_n   <= {8{~bus_data_drive}};
        first_pin_pullup <= 8'h00;
      end else begin
        first_pin_out    <= first_port_out_data;
        first_pin_oe_n   <= ~first_port_dir;
        first_pin_pullup <= hw_standby ? 8'h00
                          : (~first_port_dir & first_port_pullup_ctrl);
      end
    end
  end

  // Second-port pin drive
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      second_pin_out  <= 8'h00;
      second_pin_oe_n <= 8'hff;
    end else begin
      second_pin_out  <= mux_level;
      second_pin_oe_n <= ~mux_drive;
    end
  end

  // Alternate inputs from the second port
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_wait       <= 1'b0;
      subclock_input <= 1'b0;
    end else begin
      bus_wait       <= expand && wait_sel == WAIT_BUS && !second_sync[PIN_WAIT];
      subclock_input <= !second_port_dir[PIN_CLK] && second_sync[PIN_CLK];
    end
  end

  // Pull-up never on for an output pin
  pullup_dir_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ((first_pin_pullup & ~first_pin_oe_n) == 8'h00))
    else $error("pull-up on while pin drives");
  // Expanded means no pull-ups one cycle later
  expand_pullup_a: assert property (@(posedge core_clk) disable iff (!nrst)
    expand |=> (first_pin_pullup == 8'h00))
    else $error("pull-up on while expanded");
  // Strobe pins drive whenever expanded
  strobe_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $stable(expand) && expand |=> (second_pin_oe_n[PIN_AS:PIN_RD] == 3'h0))
    else $error("strobe pin not driven");
  // Direction register loaded from mode after reset
  dir_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !seeded |=> second_port_dir == ($past(op_mode) == MODE_ONE ? P2_DIR_MODE1 : P2_DIR_MODE23))
    else $error("bad direction reset value");
  // Second-port read mixes data and pins
  read_mix_a: assert property (@(posedge core_clk) disable iff (!nrst)
    rd && addr == ADDR_P2_DATA |=> rdata == $past(next_rdata))
    else $error("second-port read wrong");
  // Unexpanded first-port enables follow direction
  first_dir_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !expand |=> first_pin_oe_n == ~$past(first_port_dir))
    else $error("first-port direction ignored");
  // Writes land on the next edge
  write_land_a: assert property (@(posedge core_clk) disable iff (!nrst)
    seeded && wr && addr == ADDR_P2_DIR |=> second_port_dir == $past(wdata))
    else $error("direction write lost");
  // Pullup control write lands
  pullup_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wr && addr == ADDR_P1_PULLUP |=> first_port_pullup_ctrl == $past(wdata))
    else $error("pull-up write lost");
  // Hardware standby forces every pull-up off
  standby_pullup_a: assert property (@(posedge core_clk) disable iff (!nrst)
    hw_standby |=> (first_pin_pullup == 8'h00))
    else $error("pull-up on in hardware standby");
  // Expanded first port turns around with the external bus only
  bus_oe_a: assert property (@(posedge core_clk) disable iff (!nrst)
    expand |=> first_pin_oe_n == {8{!$past(bus_data_drive)}})
    else $error("data bus direction wrong");
  // Expanded low pins keep their direction bits
  gpio_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
    expand |=> second_pin_oe_n[PIN_RD-1:0] == ~$past(second_port_dir[PIN_RD-1:0]))
    else $error("low pin direction ignored");
  // Pin 6 carries the clock image whenever its direction bit is set
  clock_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
    second_port_dir[PIN_CLK] |=> !second_pin_oe_n[PIN_CLK]
      && second_pin_out[PIN_CLK] == $past(clk_phase))
    else $error("clock output missing");
  // Wait input mode leaves pin 7 released
  wait_in_a: assert property (@(posedge core_clk) disable iff (!nrst)
    expand && wait_sel == WAIT_BUS |=> second_pin_oe_n[PIN_WAIT])
    else $error("wait pin driven");
  // Bit 6 follows the pin until software takes it over
  pin6_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    seeded && p6_follow && !(wr && addr == ADDR_P2_DATA)
      |=> second_port_out_data[PIN_CLK] == $past(second_sync[PIN_CLK]))
    else $error("bit 6 lost the pin level");
  // First-port read returns stored data on output pins
  first_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    rd && addr == ADDR_P1_DATA
      |=> ((rdata ^ $past(first_port_out_data)) & $past(first_port_dir)) == 8'h00)
    else $error("first-port read wrong");
  // Only a direction write may change the direction register
  dir_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    seeded && !(wr && addr == ADDR_P2_DIR) |=> $stable(second_port_dir))
    else $error("direction changed without write");
  // Single-chip pull-ups follow control bit on input pins
  pullup_on_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !expand && !hw_standby
      |=> first_pin_pullup == ($past(first_port_pullup_ctrl) & ~$past(first_port_dir)))
    else $error("pull-up state wrong");
endmodule // gpio_ports

/* logic/pin_sync.sv */
// Two-flop synchroniser for a bus of pin levels.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module pin_sync
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Pins in, synchronised out
  input  wire logic [PORT_W-1:0] pin_raw,
  output logic      [PORT_W-1:0] pin_sync_q
);
  logic [PORT_W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1     <= '0;
      pin_sync_q <= '0;
    end else begin
      stage1     <= pin_raw;
      pin_sync_q <= stage1;
    end
  end
endmodule // pin_sync

/* logic/port_pin_mux.sv */
// Per-pin output enable and data selection for the second port.
// Assumes all controls are synchronous to core_clk; purely combinational.
`timescale 1ns/1ps
module port_pin_mux
  import gpio_pkg::*;
(
  // Controls
  input  wire logic              expand,
  input  wire logic [1:0]        wait_sel,
  input  wire logic [PORT_W-1:0] dir,
  input  wire logic [PORT_W-1:0] data,
  input  wire logic              clk_phase,
  input  wire logic [2:0]        strobes_n,
  input  wire logic              i2c_drive_low,
  // Pin drive
  output logic      [PORT_W-1:0] drive,
  output logic      [PORT_W-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pin
      // Strobe index for pins 5..3; kept in range on every other pin
      localparam int STROBE_BIT = (i >= PIN_RD && i <= PIN_AS) ? i - PIN_RD : 0;
      // Select function of pin i
      always_comb begin
        drive[i] = dir[i];
        level[i] = data[i];
        if (i == PIN_CLK) begin
          level[i] = clk_phase;
        end else if (expand && STROBE_MASK[i]) begin
          drive[i] = 1'b1;
          level[i] = strobes_n[STROBE_BIT];
        end else if (expand && i == PIN_WAIT) begin
          drive[i] = (wait_sel == WAIT_GPIO) ? dir[i]
                   : ((wait_sel == WAIT_I2C) && i2c_drive_low);
          level[i] = (wait_sel == WAIT_GPIO) ? data[i] : 1'b0;
        end
      end
    end
  endgenerate
endmodule // port_pin_mux

/* test/gpio_ports_three_four_tb.sv */
// Self-checking bench for the two-port GPIO block, random with fixed seed.
// Assumes pin_world models both pad rings; one clock, plain register port.
`timescale 1ns/1ps
module gpio_ports_three_four_tb;
  import gpio_pkg::*;
  // Stimulus
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic [1:0]        op_mode = 2'h2;
  logic              external_expansion_enable = 1'b0;
  logic              hw_standby = 1'b0;
  logic [1:0]        wait_sel = 2'h0;
  logic              i2c_drive_low = 1'b0;
  logic [2:0]        strobes_n = 3'h7;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              bus_data_drive = 1'b0;
  logic [7:0]        bus_wdata = 8'h00;
  logic [7:0]        ext1 = 8'h00;
  logic [7:0]        ext2 = 8'h00;
  logic [7:0]        got;
  logic [15:0]       seed = 16'h0063;
  int                n_fail = 0;
  int                checks_done = 0;
  // Observed
  wire logic [7:0]   rdata, p1_in, p1_out, p1_oe_n, p1_pull, bus_rdata;
  wire logic [7:0]   p2_in, p2_out, p2_oe_n;
  wire logic         bus_wait, subclk;

  gpio_ports uut (.core_clk(core_clk), .nrst(nrst), .op_mode(op_mode),
    .external_expansion_enable(external_expansion_enable), .hw_standby(hw_standby),
    .wait_sel(wait_sel), .i2c_drive_low(i2c_drive_low), .strobes_n(strobes_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .first_pin_in(p1_in), .first_pin_out(p1_out), .first_pin_oe_n(p1_oe_n),
    .first_pin_pullup(p1_pull), .bus_data_drive(bus_data_drive), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .second_pin_in(p2_in), .second_pin_out(p2_out),
    .second_pin_oe_n(p2_oe_n), .bus_wait(bus_wait), .subclock_input(subclk));
  pin_world pads1 (.out(p1_out), .oe_n(p1_oe_n), .pull(p1_pull), .ext(ext1), .level(p1_in));
  pin_world pads2 (.out(p2_out), .oe_n(p2_oe_n), .pull(8'h00), .ext(ext2), .level(p2_in));

  // 250 MHz clock
  initial forever #2 core_clk = ~core_clk;

  // Pseudo-random bytes from a 16-bit LFSR
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  // Port read: data bit for outputs, pad level for inputs
  function automatic logic [7:0] mix(logic [7:0] dir, logic [7:0] dat, logic [7:0] pad);
    return (dir & dat) | (~dir & pad);
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(logic [1:0] m);
    @(posedge core_clk);
    nrst <= 1'b0;
    op_mode <= m;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wr_reg(logic [2:0] a, logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [2:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Register, pad and two synchroniser stages all settle well inside this
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // Long enough for all scenarios several times over
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  initial begin
    logic [7:0] d1, t1, pu, d2, t2, pe;
    do_reset(2'h1);
    rd_reg(ADDR_P2_DIR); chk("p2 dir mode1", P2_DIR_MODE1, got);
    rd_reg(ADDR_STATUS); chk("status mode1", 8'h03, got);
    wr_reg(ADDR_P1_PULLUP, 8'hff);
    settle(); chk("pullup mode1", 8'h00, p1_pull);
    ext2 <= rnd();
    do_reset(2'h2);
    rd_reg(ADDR_P2_DIR); chk("p2 dir mode23", P2_DIR_MODE23, got);
    rd_reg(ADDR_P1_PULLUP); chk("pullup reset", 8'h00, got);
    rd_reg(3'h6); chk("unmapped", 8'h00, got);
    wr_reg(ADDR_P2_DIR, 8'hff);
    settle();
    rd_reg(ADDR_P2_DATA); chk("p2 data reset", ext2 & 8'h40, got);
    // Single-chip operation, standby now and then
    for (int i = 0; i < 20; i++) begin
      d1 = rnd(); t1 = rnd(); pu = rnd(); d2 = rnd() & 8'hbf; t2 = rnd();
      ext1 <= rnd();
      ext2 <= rnd();
      hw_standby <= (i % 4 == 3);
      wr_reg(ADDR_P1_DIR, d1); wr_reg(ADDR_P1_DATA, t1); wr_reg(ADDR_P1_PULLUP, pu);
      wr_reg(ADDR_P2_DIR, d2); wr_reg(ADDR_P2_DATA, t2);
      settle();
      pe = hw_standby ? 8'h00 : ~d1 & pu;
      chk("p1 oe_n", ~d1, p1_oe_n);
      chk("p1 out", t1 & d1, p1_out & d1);
      chk("p1 pullup", pe, p1_pull);
      rd_reg(ADDR_P1_DATA); chk("p1 read", mix(d1, t1, ext1 | pe), got);
      rd_reg(ADDR_P1_PULLUP); chk("pullup read", pu, got);
      rd_reg(ADDR_P2_DIR); chk("p2 dir read", d2, got);
      chk("p2 oe_n", ~d2, p2_oe_n);
      chk("p2 out", t2 & d2, p2_out & d2);
      rd_reg(ADDR_P2_DATA); chk("p2 read", mix(d2, t2, ext2), got);
    end
    wr_reg(ADDR_P2_DIR, 8'h40);
    settle(); chk("clock out oe", 8'hbf, p2_oe_n);
    // Expanded operation, every wait mode in turn
    external_expansion_enable <= 1'b1;
    hw_standby <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      d1 = rnd(); d2 = rnd(); pu = rnd();
      ext1 <= rnd();
      ext2 <= rnd();
      bus_wdata <= rnd();
      bus_data_drive <= pu[0];
      strobes_n <= pu[3:1];
      i2c_drive_low <= pu[4];
      wait_sel <= 2'(i % 3);
      wr_reg(ADDR_P1_DIR, d1); wr_reg(ADDR_P1_PULLUP, 8'hff); wr_reg(ADDR_P2_DIR, d2);
      settle();
      chk("exp pullup", 8'h00, p1_pull);
      chk("data bus oe_n", {8{~pu[0]}}, p1_oe_n);
      chk("data bus", pu[0] ? bus_wdata : ext1, pu[0] ? p1_out : bus_rdata);
      chk("strobe oe_n", 8'h00, p2_oe_n & STROBE_MASK);
      chk("strobes", {2'h0, pu[3:1], 3'h0}, p2_out & STROBE_MASK);
      chk("gpio oe_n", ~d2 & 8'h07, p2_oe_n & 8'h07);
      chk("gpio out", t2 & d2 & 8'h07, p2_out & d2 & 8'h07);
      chk("clock oe_n", ~d2 & 8'h40, p2_oe_n & 8'h40);
      pe = (wait_sel == 2'h0) ? ~d2 : (wait_sel == 2'h1) ? 8'hff : {8{~i2c_drive_low}};
      chk("pin7 oe_n", pe & 8'h80, p2_oe_n & 8'h80);
      chk("wait", {7'h0, wait_sel == 2'h1 && !ext2[7]}, {7'h0, bus_wait});
      if (!d2[6]) chk("subclock", {7'h0, ext2[6]}, {7'h0, subclk});
    end
    rd_reg(ADDR_STATUS); chk("status exp", 8'h01, got);
    print_verdict();
  end
endmodule // gpio_ports_three_four_tb

/* test/pin_world.sv */
// Far side of one 8-bit port: pads, an external driver and optional pull-ups.
// Assumes the device drives a pad while its oe_n bit is low.
`timescale 1ns/1ps
module pin_world (
  // Device side
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pull,
  // Outside world
  input  wire logic [7:0] ext,
  output logic      [7:0] level
);
  // A driven pad shows the device value, a released pad the outside level
  // lifted by any active pull-up (outside level ORed with the pull-up: high if either is high)
  assign level = (~oe_n & out) | (oe_n & (ext | pull));
endmodule // pin_world
